// >>> include/crw_pkg.sv
// Shared types, register map and field layouts of the coprocessor register write unit.
// Assumes one clock and a register file that classifies the register it is asked about.
package crw_pkg;

    // Wishbone register map, byte addresses
    localparam logic [7:0] CRW_ADR_CTRL = 8'h00;
    localparam logic [7:0] CRW_ADR_STAT = 8'h04;
    localparam logic [7:0] CRW_ADR_MASK = 8'h08;
    localparam logic [7:0] CRW_ADR_LAST = 8'h0C;
    localparam logic [7:0] CRW_ADR_CNT  = 8'h10;

    // Values after reset
    localparam logic [6:0]  CRW_CTRL_RST = 7'h78;
    localparam logic [3:0]  CRW_STAT_RST = 4'h0;
    localparam logic [3:0]  CRW_MASK_RST = 4'h0;
    localparam logic [11:0] CRW_LAST_RST = 12'h000;
    localparam logic [15:0] CRW_CNT_RST  = 16'h0000;

    // Event bit positions in status and mask
    localparam int CRW_EV_DONE  = 0;
    localparam int CRW_EV_IGN   = 1;
    localparam int CRW_EV_UNDEF = 2;
    localparam int CRW_EV_CU    = 3;

    // Write masks of a 64-bit target
    localparam logic [63:0] CRW_M_ALL = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [63:0] CRW_M_LO  = 64'h0000_0000_FFFF_FFFF;
    localparam logic [63:0] CRW_M_HI  = 64'hFFFF_FFFF_0000_0000;
    localparam logic [63:0] CRW_M_ELH = 64'h3FFF_FFFF_C000_0000;

    typedef enum logic [3:0] {
        CRW_OP_LOW  = 4'h1,
        CRW_OP_HIGH = 4'h2,
        CRW_OP_FPR  = 4'h4,
        CRW_OP_COP2 = 4'h8
    } crw_op_t;

    typedef enum logic [7:0] {
        CRW_K_OTHER = 8'h01,
        CRW_K_ELO   = 8'h02,
        CRW_K_EHI   = 8'h04,
        CRW_K_MEMORY_ATTRIBUTE_REG  = 8'h08,
        CRW_K_CACHE_TAG_LOW = 8'h10,
        CRW_K_LLADR = 8'h20,
        CRW_K_BADVA = 8'h40,
        CRW_K_WATCH = 8'h80
    } crw_kind_t;

    typedef struct packed {
        logic cu2;
        logic cu1;
        logic cu0;
        logic rel6;
        logic vz;
        logic large_phys_addr_enable;
        logic extended_phys_addressing;
    } crw_ctrl_t;

    typedef struct packed {
        crw_op_t     op;
        logic [4:0]  rd;
        logic [2:0]  sel;
        logic [15:0] impl;
        logic [63:0] data;
    } crw_req_t;

    typedef struct packed {
        logic      implemented;
        logic      width64;
        logic      extended;
        logic      tag_writable;
        crw_kind_t kind;
    } crw_attr_t;

    typedef struct packed {
        logic        we;
        logic [4:0]  rd;
        logic [2:0]  sel;
        logic [63:0] data;
        logic [63:0] mask;
    } crw_cp0_wr_t;

    function automatic logic [63:0] crw_elo_low(input logic [31:0] w);
        return {w[31], w[30], 32'h0000_0000, w[29:0]};
    endfunction

    function automatic logic [63:0] crw_elo_high(input logic [31:0] w);
        return {2'b00, w[31:2], w[1:0], 30'h0000_0000};
    endfunction

    function automatic logic [31:0] crw_be_merge(input logic [31:0] old_v,
                                                 input logic [31:0] new_v,
                                                 input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i])
                r[8*i +: 8] = new_v[8*i +: 8];
        end
        return r;
    endfunction

endpackage

// >>> verilog/crw_pack.sv
// Data and mask shaping of system-control writes, purely combinational.
// Assumes attr_i describes the register that req_i names in the same cycle.
`timescale 1ns/1ns
module crw_pack
    import crw_pkg::*;
(
    input  wire crw_pkg::crw_req_t    req_i,
    input  wire crw_pkg::crw_attr_t   attr_i,
    input  wire crw_pkg::crw_ctrl_t   ctrl_i,
    output crw_pkg::crw_cp0_wr_t      wr_o,
    output logic                      ignore_o,
    output logic                      undef_o
);
    import crw_pkg::*;

    wire        is_low  = (req_i.op == CRW_OP_LOW);
    wire        is_high = (req_i.op == CRW_OP_HIGH);
    wire        is_elo  = (attr_i.kind == CRW_K_ELO);
    wire [31:0] word    = req_i.data[31:0];

    // Registers that only exist wide because of extended addressing
    wire xpa_kind = attr_i.kind inside {CRW_K_ELO, CRW_K_EHI, CRW_K_MEMORY_ATTRIBUTE_REG,
                                        CRW_K_CACHE_TAG_LOW, CRW_K_LLADR, CRW_K_BADVA};

    // Watchpoint-high only counts as extended in the latest release
    wire ext_ok = attr_i.implemented && attr_i.extended
                  && (attr_i.kind != CRW_K_WATCH || ctrl_i.rel6)
                  && (!xpa_kind || ctrl_i.extended_phys_addressing);

    // Read-only linked-load and faulting-address keep their upper half
    wire clr_hi = (ctrl_i.extended_phys_addressing && ctrl_i.large_phys_addr_enable
                   && (attr_i.kind == CRW_K_MEMORY_ATTRIBUTE_REG
                       || (attr_i.kind == CRW_K_CACHE_TAG_LOW && attr_i.tag_writable)))
                  || (ctrl_i.extended_phys_addressing && ctrl_i.vz && attr_i.kind == CRW_K_EHI);

    wire [63:0] low_data = is_elo         ? crw_elo_low(word) :
                           attr_i.width64 ? req_i.data :
                                            {32'h0000_0000, word};
    wire [63:0] low_mask = (is_elo || attr_i.width64 || clr_hi) ? CRW_M_ALL : CRW_M_LO;

    // Masked halves make a low then high pair land as one combined value
    wire [63:0] high_data = is_elo ? crw_elo_high(word)
                                   : {word, 32'h0000_0000};
    wire [63:0] high_mask = is_elo ? CRW_M_ELH : CRW_M_HI;

    wire target_ok = is_low ? attr_i.implemented : ext_ok;
    wire missed    = (is_low || is_high) && !target_ok;

    assign wr_o.we   = (is_low || is_high) && target_ok;
    assign wr_o.rd   = req_i.rd;
    assign wr_o.sel  = req_i.sel;
    assign wr_o.data = is_high ? high_data : low_data;
    assign wr_o.mask = is_high ? high_mask : low_mask;
    assign ignore_o  = missed && ctrl_i.rel6;
    assign undef_o   = missed && !ctrl_i.rel6;

endmodule // crw_pack

// >>> verilog/crw_top.sv
// Move-to-coprocessor write unit: shapes register writes for coprocessors 0, 1 and 2.
// Assumes one 10 MHz clock, a classic Wishbone master and a single-cycle request port.
//
// Notes on behaviour
// - Low move writes register chosen by rd and sel
// - Entry-low: bits 31:30 to 63:62, clear 61:30
// - Wide target gets 64 bits, narrow 32
// - Low move zeroes high bits of entry-low; other narrow registers keep them unless cleared below
// - Extended addressing clears high half of chosen registers
// - With virtualization, entry-high high half cleared
// - Latest release ignores low writes to missing registers
// - Float move writes low word, high unspecified
// - High move writes bits 63:32 of extended register
// - Entry-low high move shifts right by two
// - Shift happens even without inhibit bit support
// - Low then high entry-low writes combine atomically
// - Latest release ignores high writes to unextended registers
// - Extended set: addressing registers plus watchpoint-high
`timescale 1ns/1ns
module crw_top
    import crw_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [7:0]            adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [31:0]           dat_i,
    output logic [31:0]                dat_o,
    output logic                       ack_o,
    input  wire logic                  req_valid_i,
    input  wire crw_pkg::crw_req_t     req_i,
    input  wire crw_pkg::crw_attr_t    attr_i,
    output crw_pkg::crw_cp0_wr_t       cp0_wr_o,
    output logic                       fpr_we_o,
    output logic [4:0]                 fpr_idx_o,
    output logic [31:0]                fpr_data_o,
    output logic                       cop2_we_o,
    output logic [15:0]                cop2_impl_o,
    output logic [31:0]                cop2_data_o,
    output logic                       cu_exc_o,
    output logic [1:0]                 cu_num_o,
    output logic                       irq_o
);
    import crw_pkg::*;

    crw_ctrl_t   ctrl_q;
    logic [3:0]  stat_q;
    logic [3:0]  mask_q;
    logic [11:0] last_q;
    logic [15:0] cnt_q;
    logic        ack_q;
    logic [31:0] rdat_q;

    crw_cp0_wr_t cp0_q;
    logic        fpr_we_q;
    logic [4:0]  fpr_idx_q;
    logic [31:0] fpr_data_q;
    logic        cop2_we_q;
    logic [15:0] cop2_impl_q;
    logic [31:0] cop2_data_q;
    logic        cu_exc_q;
    logic [1:0]  cu_num_q;

    crw_cp0_wr_t pack_wr;
    logic        pack_ign;
    logic        pack_undef;

    crw_pack u_pack (
        .req_i    (req_i),
        .attr_i   (attr_i),
        .ctrl_i   (ctrl_q),
        .wr_o     (pack_wr),
        .ignore_o (pack_ign),
        .undef_o  (pack_undef)
    );

    // Request side decode
    wire is_cp0  = (req_i.op == CRW_OP_LOW) || (req_i.op == CRW_OP_HIGH);
    wire is_fpr  = (req_i.op == CRW_OP_FPR);
    wire is_cop2 = (req_i.op == CRW_OP_COP2);

    wire cu_ok = is_cp0  ? ctrl_q.cu0 :
                 is_fpr  ? ctrl_q.cu1 :
                 is_cop2 ? ctrl_q.cu2 : 1'b0;

    wire take     = req_valid_i && cu_ok;
    wire refuse   = req_valid_i && !cu_ok;
    wire [1:0] cu_num_d = is_cp0 ? 2'd0 : is_fpr ? 2'd1 : 2'd2;

    wire ev_done  = take && (pack_wr.we || is_fpr || is_cop2);
    wire ev_ign   = take && is_cp0 && pack_ign;
    wire ev_undef = take && is_cp0 && pack_undef;
    wire [3:0] ev = {refuse, ev_undef, ev_ign, ev_done};

    // Wishbone decode; writes land on the edge that sees ack high
    wire wb_req  = cyc_i && stb_i;
    wire wb_wr   = wb_req && we_i && ack_q;
    wire hit_ctl = (adr_i == CRW_ADR_CTRL);
    wire hit_st  = (adr_i == CRW_ADR_STAT);
    wire hit_msk = (adr_i == CRW_ADR_MASK);
    wire hit_lst = (adr_i == CRW_ADR_LAST);
    wire hit_cnt = (adr_i == CRW_ADR_CNT);

    wire [31:0] ctrl_m = crw_be_merge({25'h0, ctrl_q}, dat_i, sel_i);
    wire [31:0] mask_m = crw_be_merge({28'h0, mask_q}, dat_i, sel_i);
    wire [31:0] w1c_m  = crw_be_merge(32'h0000_0000, dat_i, sel_i);

    // Unmapped addresses read zero and drop writes
    wire [31:0] rdat_d = hit_ctl ? {25'h0, ctrl_q} :
                         hit_st  ? {28'h0, stat_q} :
                         hit_msk ? {28'h0, mask_q} :
                         hit_lst ? {20'h0, last_q} :
                         hit_cnt ? {16'h0, cnt_q}  : 32'h0000_0000;

    // A new event outweighs a clear in the same cycle
    wire [3:0] w1c    = (wb_wr && hit_st) ? w1c_m[3:0] : 4'h0;
    wire [3:0] stat_d = (stat_q & ~w1c) | ev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= wb_req && !ack_q;
            rdat_q <= rdat_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CRW_CTRL_RST;
            mask_q <= CRW_MASK_RST;
            stat_q <= CRW_STAT_RST;
        end else begin
            if (wb_wr && hit_ctl)
                ctrl_q <= ctrl_m[6:0];
            if (wb_wr && hit_msk)
                mask_q <= mask_m[3:0];
            stat_q <= stat_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_q <= CRW_LAST_RST;
            cnt_q  <= CRW_CNT_RST;
        end else if (req_valid_i) begin
            last_q <= {req_i.op, req_i.rd, req_i.sel};
            cnt_q  <= cnt_q + {15'h0, ev_done};
        end
    end

    // Coprocessor 0 write port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cp0_q <= '0;
        end else begin
            cp0_q    <= pack_wr;
            cp0_q.we <= take && pack_wr.we;
        end
    end

    // Float and coprocessor 2 ports carry only the low word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fpr_we_q    <= 1'b0;
            fpr_idx_q   <= 5'h00;
            fpr_data_q  <= 32'h0000_0000;
            cop2_we_q   <= 1'b0;
            cop2_impl_q <= 16'h0000;
            cop2_data_q <= 32'h0000_0000;
        end else begin
            fpr_we_q    <= take && is_fpr;
            fpr_idx_q   <= req_i.rd;
            fpr_data_q  <= req_i.data[31:0];
            cop2_we_q   <= take && is_cop2;
            cop2_impl_q <= req_i.impl;
            cop2_data_q <= req_i.data[31:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cu_exc_q <= 1'b0;
            cu_num_q <= 2'd0;
        end else begin
            cu_exc_q <= refuse;
            cu_num_q <= cu_num_d;
        end
    end

    assign ack_o       = ack_q;
    assign dat_o       = rdat_q;
    assign cp0_wr_o    = cp0_q;
    assign fpr_we_o    = fpr_we_q;
    assign fpr_idx_o   = fpr_idx_q;
    assign fpr_data_o  = fpr_data_q;
    assign cop2_we_o   = cop2_we_q;
    assign cop2_impl_o = cop2_impl_q;
    assign cop2_data_o = cop2_data_q;
    assign cu_exc_o    = cu_exc_q;
    assign cu_num_o    = cu_num_q;
    assign irq_o       = |(stat_q & mask_q);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    wire low_go  = take && req_i.op == CRW_OP_LOW && attr_i.implemented;
    wire high_go = take && req_i.op == CRW_OP_HIGH;

    sequence s_low_elo;
        low_go && attr_i.kind == CRW_K_ELO;
    endsequence

    sequence s_cp0_out(logic [63:0] d, logic [63:0] m);
        cp0_wr_o.we && cp0_wr_o.data == d && cp0_wr_o.mask == m;
    endsequence

    low_elo_a: assert property (s_low_elo |=>
        s_cp0_out(crw_elo_low($past(req_i.data[31:0])), CRW_M_ALL))
        else $error("entry-low low write misplaced");

    wide_write_a: assert property (
        low_go && attr_i.width64 && attr_i.kind != CRW_K_ELO
        |=> s_cp0_out($past(req_i.data), CRW_M_ALL))
        else $error("wide target lost upper bits");

    memory_attribute_reg_clear_a: assert property (
        low_go && !attr_i.width64 && ctrl_q.extended_phys_addressing && ctrl_q.large_phys_addr_enable
        && attr_i.kind == CRW_K_MEMORY_ATTRIBUTE_REG
        |=> s_cp0_out({32'h0000_0000, $past(req_i.data[31:0])}, CRW_M_ALL))
        else $error("attribute register high half kept");

    ro_keep_a: assert property (
        low_go && !attr_i.width64
        && attr_i.kind inside {CRW_K_LLADR, CRW_K_BADVA}
        |=> cp0_wr_o.mask == CRW_M_LO)
        else $error("read-only register high half touched");

    ehi_clear_a: assert property (
        low_go && !attr_i.width64 && ctrl_q.extended_phys_addressing && ctrl_q.vz
        && attr_i.kind == CRW_K_EHI
        |=> cp0_wr_o.mask == CRW_M_ALL && cp0_wr_o.data[63:32] == 32'h0000_0000)
        else $error("entry-high upper half not cleared");

    low_ignore_a: assert property (
        take && req_i.op == CRW_OP_LOW && !attr_i.implemented && ctrl_q.rel6
        |=> !cp0_wr_o.we && stat_q[CRW_EV_IGN])
        else $error("write to missing register not ignored");

    high_elo_a: assert property (
        high_go && attr_i.extended && attr_i.implemented && ctrl_q.extended_phys_addressing
        && attr_i.kind == CRW_K_ELO
        |=> s_cp0_out(crw_elo_high($past(req_i.data[31:0])), CRW_M_ELH))
        else $error("entry-low high write misplaced");

    high_unext_a: assert property (
        high_go && !attr_i.extended && ctrl_q.rel6
        |=> !cp0_wr_o.we ##1 !cp0_wr_o.we || $past(req_valid_i))
        else $error("high write to narrow register done");

    fpr_word_a: assert property (
        take && is_fpr |=> fpr_we_o && fpr_data_o == $past(req_i.data[31:0])
        && !cp0_wr_o.we)
        else $error("float word move wrong");

    cop2_word_a: assert property (
        take && is_cop2 |=> cop2_we_o && cop2_impl_o == $past(req_i.impl))
        else $error("cop2 word move wrong");

    cu_block_a: assert property (refuse |=>
        cu_exc_o && !cp0_wr_o.we && !fpr_we_o && !cop2_we_o)
        else $error("disabled coprocessor was written");

    sequence s_bus_answer;
        ack_o ##1 !ack_o;
    endsequence

    bus_ack_a: assert property (wb_req && !ack_o |=> s_bus_answer)
        else $error("bus answer not one cycle");

    irq_raise_a: assert property (refuse && mask_q[CRW_EV_CU] |=> irq_o)
        else $error("masked-in event gave no interrupt");

    high_word_a: assert property (
        high_go && attr_i.kind == CRW_K_MEMORY_ATTRIBUTE_REG && attr_i.extended && attr_i.implemented
        && ctrl_q.extended_phys_addressing |=> s_cp0_out({$past(req_i.data[31:0]), 32'h0000_0000}, CRW_M_HI))
        else $error("high word misplaced");

    watch_high_a: assert property (
        high_go && attr_i.kind == CRW_K_WATCH && attr_i.extended && attr_i.implemented
        |=> cp0_wr_o.we == $past(ctrl_q.rel6))
        else $error("watchpoint-high extension wrong");

    narrow_low_a: assert property (
        low_go && !attr_i.width64 && attr_i.kind == CRW_K_OTHER
        |=> cp0_wr_o.we && cp0_wr_o.data[63:32] == 32'h0000_0000)
        else $error("narrow low write kept high bits");

    low_undef_a: assert property (
        take && req_i.op == CRW_OP_LOW && !attr_i.implemented && !ctrl_q.rel6
        |=> !cp0_wr_o.we && stat_q[CRW_EV_UNDEF])
        else $error("undefined low write not flagged");

    cu_number_a: assert property (
        refuse && is_cop2 |=> cu_num_o == 2'd2)
        else $error("unusable coprocessor number wrong");

    fpr_index_a: assert property (
        take && is_fpr |=> fpr_idx_o == $past(req_i.rd))
        else $error("float register index wrong");

    cop2_data_a: assert property (
        take && is_cop2 |=> cop2_data_o == $past(req_i.data[31:0]))
        else $error("cop2 word data wrong");

    ctrl_write_a: assert property (
        wb_wr && hit_ctl && sel_i == 4'hF |=> ctrl_q == $past(dat_i[6:0]))
        else $error("control write lost");

    done_flag_a: assert property (ev_done |=> stat_q[CRW_EV_DONE])
        else $error("done event not sticky");

    // Low then high to one entry-low: full mask, then the middle bits
    sequence s_elo_pair;
        s_low_elo ##1 (high_go && attr_i.kind == CRW_K_ELO && attr_i.extended && ctrl_q.extended_phys_addressing);
    endsequence

    elo_pair_a: assert property (
        s_elo_pair |=> cp0_wr_o.we && cp0_wr_o.mask == CRW_M_ELH
        && $past(cp0_wr_o.we) && $past(cp0_wr_o.mask) == CRW_M_ALL)
        else $error("entry-low pair not combined");

endmodule // crw_top

// >>> bench/crw_cop_model.sv
// Behavioural register file of the system-control coprocessor.
// Assumes writes arrive as the unit's masked write struct, one per cycle.
`timescale 1ns/1ns
module crw_cop_model
    import crw_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic [4:0]           rd_i,
    output crw_pkg::crw_attr_t        attr_o,
    input  wire crw_pkg::crw_cp0_wr_t wr_i,
    input  wire logic [4:0]           peek_i,
    output logic [63:0]               peek_o
);
    logic [63:0] regs [32];

    initial begin
        for (int i = 0; i < 32; i++) begin
            regs[i] = 64'h0;
        end
    end

    // Implemented, width64, extended, tag_writable, then kind
    always_comb begin
        case (rd_i)
            5'd2, 5'd3: attr_o = {4'hA, CRW_K_ELO};
            5'd8:       attr_o = {4'hA, CRW_K_BADVA};
            5'd9:       attr_o = {4'hC, CRW_K_OTHER};
            5'd10:      attr_o = {4'hA, CRW_K_EHI};
            5'd12:      attr_o = {4'h8, CRW_K_OTHER};
            5'd17:      attr_o = {4'hA, CRW_K_MEMORY_ATTRIBUTE_REG};
            5'd19:      attr_o = {4'hA, CRW_K_WATCH};
            5'd28:      attr_o = {4'hB, CRW_K_CACHE_TAG_LOW};
            default:    attr_o = {4'h0, CRW_K_OTHER};
        endcase
    end

    // Bits outside the mask keep their value, so a low/high pair composes
    always @(posedge clk_i) begin
        if (wr_i.we === 1'b1) begin
            regs[wr_i.rd] <= (regs[wr_i.rd] & ~wr_i.mask) | (wr_i.data & wr_i.mask);
        end
    end

    assign peek_o = regs[peek_i];
endmodule // crw_cop_model

// >>> bench/crw_top_tb_top.sv
// Self-checking bench of the coprocessor register write unit.
// Assumes the register file model answers attributes in the same cycle.
`timescale 1ns/1ns
module crw_top_tb_top;
    import crw_pkg::*;
    typedef struct packed {
        logic [1:0]  k;
        logic [63:0] d;
        logic [63:0] m;
        logic [15:0] x;
    } crw_note_t;
    typedef struct packed {
        logic [6:0]  ctrl;
        crw_op_t     op;
        logic [4:0]  rd;
        logic [63:0] m;
        logic [3:0]  st;
    } crw_case_t;

    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic        req_valid_i = 1'b0, ack_o, fpr_we_o, cop2_we_o, cu_exc_o, irq_o;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, fpr_data_o, cop2_data_o, r, w, h;
    logic [31:0] seed = 32'hB42D;
    logic [4:0]  fpr_idx_o, peek = 5'h0;
    logic [15:0] cop2_impl_o;
    logic [1:0]  cu_num_o;
    logic [63:0] d, peek_o;
    crw_req_t    req_i = '0;
    crw_attr_t   attr_i;
    crw_cp0_wr_t cp0_wr_o;
    crw_note_t   notes[$];
    crw_op_t     cops [3] = '{CRW_OP_LOW, CRW_OP_FPR, CRW_OP_COP2};
    int          tests_run = 0, fail_count = 0;
    crw_case_t   tbl [16] = '{
        '{7'h78, CRW_OP_LOW,  5'd9,  CRW_M_ALL, 4'h1},
        '{7'h78, CRW_OP_LOW,  5'd12, CRW_M_LO,  4'h1},
        '{7'h78, CRW_OP_LOW,  5'd17, CRW_M_LO,  4'h1},
        '{7'h7B, CRW_OP_LOW,  5'd17, CRW_M_ALL, 4'h1},
        '{7'h7B, CRW_OP_LOW,  5'd28, CRW_M_ALL, 4'h1},
        '{7'h7B, CRW_OP_LOW,  5'd8,  CRW_M_LO,  4'h1},
        '{7'h7B, CRW_OP_LOW,  5'd10, CRW_M_LO,  4'h1},
        '{7'h7F, CRW_OP_LOW,  5'd10, CRW_M_ALL, 4'h1},
        '{7'h78, CRW_OP_HIGH, 5'd19, CRW_M_HI,  4'h1},
        '{7'h7B, CRW_OP_HIGH, 5'd17, CRW_M_HI,  4'h1},
        '{7'h78, CRW_OP_HIGH, 5'd17, 64'h0,     4'h2},
        '{7'h78, CRW_OP_HIGH, 5'd12, 64'h0,     4'h2},
        '{7'h78, CRW_OP_HIGH, 5'd9,  64'h0,     4'h2},
        '{7'h78, CRW_OP_LOW,  5'd31, 64'h0,     4'h2},
        '{7'h70, CRW_OP_LOW,  5'd31, 64'h0,     4'h4},
        '{7'h70, CRW_OP_HIGH, 5'd19, 64'h0,     4'h4}};

    always #50 clk_i = ~clk_i;

    crw_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .req_valid_i(req_valid_i), .req_i(req_i), .attr_i(attr_i), .cp0_wr_o(cp0_wr_o),
        .fpr_we_o(fpr_we_o), .fpr_idx_o(fpr_idx_o), .fpr_data_o(fpr_data_o),
        .cop2_we_o(cop2_we_o), .cop2_impl_o(cop2_impl_o), .cop2_data_o(cop2_data_o),
        .cu_exc_o(cu_exc_o), .cu_num_o(cu_num_o), .irq_o(irq_o));

    crw_cop_model u_model (.clk_i(clk_i), .rd_i(req_i.rd), .attr_o(attr_i),
        .wr_i(cp0_wr_o), .peek_i(peek), .peek_o(peek_o));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        if (notes.size() != 0) begin
            fail_count++;
        end
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] v,
                      output logic [31:0] rv);
        int i;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= wr;
        adr_i <= a;
        dat_i <= v;
        sel_i <= 4'hF;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        if (i == 20) begin
            fail_count++;
            complete_run();
        end
        rv = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, r);
        chk("register_read", {32'h0, e}, {32'h0, r});
    endtask

    task automatic note(input logic [1:0] k, input logic [63:0] dv, input logic [63:0] m,
                        input logic [15:0] x);
        notes.push_back('{k, dv, m, x});
    endtask

    // Valid stays up between calls so back-to-back moves need no gap
    task automatic mv(input crw_op_t op, input logic [4:0] rd, input logic [15:0] im,
                      input logic [63:0] dv);
        req_valid_i <= 1'b1;
        req_i <= '{op: op, rd: rd, sel: 3'h0, impl: im, data: dv};
        @(posedge clk_i);
    endtask

    task automatic idle();
        req_valid_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic take(input logic [1:0] k, input logic [63:0] dv, input logic [63:0] m,
                        input logic [15:0] x);
        crw_note_t n;
        if (notes.size() == 0) begin
            chk("pending_notes", 64'h1, 64'h0);
        end else begin
            n = notes.pop_front();
            chk("result_kind", {62'h0, n.k}, {62'h0, k});
            chk("result_data", n.d, dv);
            chk("result_mask", n.m, m);
            chk("result_index", {48'h0, n.x}, {48'h0, x});
        end
    endtask

    always @(posedge clk_i) begin
        if (rst_i === 1'b0) begin
            if (cp0_wr_o.we === 1'b1) take(2'd0, cp0_wr_o.data, cp0_wr_o.mask, {8'h0, cp0_wr_o.sel, cp0_wr_o.rd});
            if (fpr_we_o === 1'b1) take(2'd1, {32'h0, fpr_data_o}, 64'h0, {11'h0, fpr_idx_o});
            if (cop2_we_o === 1'b1) take(2'd2, {32'h0, cop2_data_o}, 64'h0, cop2_impl_o);
            if (cu_exc_o === 1'b1) take(2'd3, 64'h0, 64'h0, {14'h0, cu_num_o});
        end
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdchk(CRW_ADR_CTRL, 32'h78);
        rdchk(CRW_ADR_STAT, 32'h0);
        rdchk(CRW_ADR_MASK, 32'h0);
        rdchk(8'h40, 32'h0);
        $display("test reset_values done");
        // High moves to entry-low need extended addressing on
        wb(1'b1, CRW_ADR_CTRL, 32'h79, r);
        for (int e = 2; e < 4; e++) begin
            w = rnd();
            h = rnd();
            peek <= e[4:0];
            note(2'd0, {w[31:30], 32'h0, w[29:0]}, CRW_M_ALL, e[15:0]);
            note(2'd0, {2'b00, h, 30'h0}, CRW_M_ELH, e[15:0]);
            mv(CRW_OP_LOW, e[4:0], 16'h0, {rnd(), w});
            mv(CRW_OP_HIGH, e[4:0], 16'h0, {rnd(), h});
            repeat (3) idle();
            chk("entry_low", {w[31:30], h, w[29:0]}, peek_o);
        end
        $display("test entry_low_pair done");
        for (int i = 0; i < 16; i++) begin
            wb(1'b1, CRW_ADR_CTRL, {25'h0, tbl[i].ctrl}, r);
            wb(1'b1, CRW_ADR_STAT, 32'hF, r);
            w = rnd();
            h = rnd();
            d = {32'h0, w};
            if (tbl[i].m == CRW_M_HI) d = {w, 32'h0};
            if (tbl[i].rd == 5'd9) d = {h, w};
            if (tbl[i].m != 64'h0) note(2'd0, d, tbl[i].m, {11'h0, tbl[i].rd});
            mv(tbl[i].op, tbl[i].rd, 16'h0, {h, w});
            idle();
            idle();
            rdchk(CRW_ADR_STAT, {28'h0, tbl[i].st});
        end
        $display("test system_control_table done");
        wb(1'b1, CRW_ADR_CTRL, 32'h78, r);
        w = rnd();
        note(2'd1, {32'h0, w}, 64'h0, 16'h5);
        mv(CRW_OP_FPR, 5'd5, 16'h0, {rnd(), w});
        note(2'd2, {32'h0, w}, 64'h0, 16'h3);
        mv(CRW_OP_COP2, 5'd0, 16'h3, {rnd(), w});
        idle();
        idle();
        for (int c = 0; c < 3; c++) begin
            wb(1'b1, CRW_ADR_CTRL, 32'h78 ^ (32'h10 << c), r);
            wb(1'b1, CRW_ADR_STAT, 32'hF, r);
            note(2'd3, 64'h0, 64'h0, c[15:0]);
            mv(cops[c], 5'd12, 16'h3, {rnd(), rnd()});
            idle();
            idle();
            chk("irq_masked", 64'h0, {63'h0, irq_o});
            rdchk(CRW_ADR_STAT, 32'h8);
            wb(1'b1, CRW_ADR_MASK, 32'h8, r);
            idle();
            chk("irq_raised", 64'h1, {63'h0, irq_o});
            wb(1'b1, CRW_ADR_STAT, 32'h8, r);
            idle();
            chk("irq_cleared", 64'h0, {63'h0, irq_o});
            note(2'd3, 64'h0, 64'h0, c[15:0]);
            mv(cops[c], 5'd12, 16'h3, {rnd(), rnd()});
            idle();
            chk("irq_again", 64'h1, {63'h0, irq_o});
            wb(1'b1, CRW_ADR_STAT, 32'h8, r);
            wb(1'b1, CRW_ADR_MASK, 32'h0, r);
        end
        $display("test float_cop2_unusable done");
        rdchk(CRW_ADR_LAST, 32'h860);
        rdchk(CRW_ADR_CNT, 32'h10);
        idle();
        complete_run();
    end
endmodule // crw_top_tb_top
